/* hw/sapf_pkg.sv */
package sapf_pkg;

  // ==========================================================================
  // Main control register
  localparam logic [7:0] MAIN_CONTROL_ADDR  = 8'h01;
  localparam logic [7:0] MAIN_CONTROL_RESET = 8'h41;
  localparam int         WLEN_LSB           = 0;
  localparam int         IN_FMT_LSB         = 2;
  localparam int         OUT_FMT_LSB        = 4;
  localparam int         RATIO_BIT          = 6;

  // ==========================================================================
  // Field encodings
  localparam logic [1:0] FMT_LEFT_JUST  = 2'h0;
  localparam logic [1:0] FMT_RIGHT_JUST = 2'h1;
  localparam logic [1:0] FMT_I2S        = 2'h2;
  localparam logic [1:0] WLEN_16        = 2'h0;
  localparam logic [1:0] WLEN_18        = 2'h1;
  localparam logic [1:0] WLEN_20        = 2'h2;
  localparam int         WORD_MAX       = 20;

  // ==========================================================================
  // Clock generation: master clock is 256 fs
  localparam int         MCLK_PER_FS    = 256;
  localparam int         BITS_PER_FS_64 = 64;
  localparam int         BITS_PER_FS_32 = 32;
  localparam logic [2:0] DIV_64         = 3'(MCLK_PER_FS / BITS_PER_FS_64 - 1);
  localparam logic [2:0] DIV_32         = 3'(MCLK_PER_FS / BITS_PER_FS_32 - 1);

  typedef enum logic [1:0] {
    SAPF_IDLE  = 2'b00,
    SAPF_SHIFT = 2'b01,
    SAPF_DONE  = 2'b11
  } sapf_rx_state_t;

endpackage

/* hw/sapf_rx_chan.sv */
`timescale 1ns/10ps
// Deserialises one serial data input into a left and a right word.
module sapf_rx_chan (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        bit_rise,
  input  wire logic        ws_level,
  input  wire logic        ws_edge,
  input  wire logic        data_in,
  input  wire logic [1:0]  fmt,
  input  wire logic [4:0]  wlen,
  output logic      [19:0] left_word,
  output logic      [19:0] right_word,
  output logic             word_strobe
);

  logic        left_now;
  logic [5:0]  cnt_q, cnt_d;
  logic [5:0]  start_bit;
  logic [19:0] sh_q, sh_d;
  logic [19:0] lw_q, lw_d, rw_q, rw_d;
  logic        stb_q, stb_d;
  logic        was_left_q, was_left_d;
  logic [5:0]  last_cnt_q, last_cnt_d;

  // ==========================================================================
  // Channel polarity and alignment
  assign left_now  = (fmt == sapf_pkg::FMT_I2S) ? ~ws_level : ws_level;
  assign start_bit = (fmt == sapf_pkg::FMT_I2S) ? 6'd1 : 6'd0;

  always_comb begin
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    lw_d       = lw_q;
    rw_d       = rw_q;
    stb_d      = 1'b0;
    was_left_d = was_left_q;
    last_cnt_d = last_cnt_q;
    if (bit_rise) begin
      if (ws_edge) begin
        // Phase ended: the previous word is complete in the shifter
        if (was_left_q) begin
          lw_d = sh_q;
        end else begin
          rw_d = sh_q;
        end
        stb_d      = ~was_left_q;
        last_cnt_d = cnt_q;
        was_left_d = left_now;
        cnt_d      = 6'd1;
        sh_d       = 20'h00000;
        if (fmt != sapf_pkg::FMT_I2S) begin
          sh_d = {19'h00000, data_in};
        end
      end else begin
        cnt_d = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'd1;
        if (fmt == sapf_pkg::FMT_RIGHT_JUST) begin
          // Keep the last bits received: word ends at trailing edge
          sh_d = {sh_q[18:0], data_in};
        end else if (cnt_q >= start_bit && (cnt_q - start_bit) < {1'b0, wlen}) begin
          sh_d = {sh_q[18:0], data_in};
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q      <= 6'd0;
      sh_q       <= 20'h00000;
      lw_q       <= 20'h00000;
      rw_q       <= 20'h00000;
      stb_q      <= 1'b0;
      was_left_q <= 1'b0;
      last_cnt_q <= 6'd0;
    end else begin
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      lw_q       <= lw_d;
      rw_q       <= rw_d;
      stb_q      <= stb_d;
      was_left_q <= was_left_d;
      last_cnt_q <= last_cnt_d;
    end
  end

  // Words are MSB-aligned at bit 19 whatever the length
  assign left_word   = (right_just_mask(lw_q, wlen)) << (6'd20 - {1'b0, wlen});
  assign right_word  = (right_just_mask(rw_q, wlen)) << (6'd20 - {1'b0, wlen});
  assign word_strobe = stb_q;

  function automatic logic [19:0] right_just_mask(input logic [19:0] w, input logic [4:0] n);
    right_just_mask = w & ((20'h00001 << n) - 20'h00001);
  endfunction

endmodule // sapf_rx_chan

/* hw/sapf_port.sv */
`timescale 1ns/10ps
// Summary of operation
// - Input side is slave only; word-select and bit clock are inputs, never driven.
// - Word lengths 16, 18, 20 bits in I2S, left- and right-justified formats.
// - Both serial inputs are received using word-select and bit clock inputs.
// - Generated word-select and bit clocks come from master clock; output follows them.
// - Bit clock is 64 fs; 16-bit left-justified may use 32 fs when ratio bit clear.
// - Control bits 3-2 select input format: LJ, RJ or I2S.
// - Control bits 5-4 select output format independently.
// - Control register at subaddress 01h; bits 1-0 select word length.
// - In I2S, left while word-select low, right while high.
// - Input sampled on rising bit clock; output changes on falling bit clock.
// - In justified formats, left while word-select high, right while low.
// - Left-justified MSB comes with word-select edge, captured on next rising edge.
// - Right-justified word ends at trailing edge of its word-select phase.
// - Logic is sequenced by the master-clock derived system clock.
// - Either own generated clocks or an external master drive the clock inputs.
module sapf_port (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        word_select_clock,
  input  wire logic        bit_clock,
  input  wire logic        serial_in_a,
  input  wire logic        serial_in_b,
  output logic             serial_out,
  output logic             word_select_gen,
  output logic             bit_clock_gen,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic      [19:0] in_a_left,
  output logic      [19:0] in_a_right,
  output logic      [19:0] in_b_left,
  output logic      [19:0] in_b_right,
  output logic             in_valid,
  input  wire logic [19:0] out_left,
  input  wire logic [19:0] out_right,
  output logic             out_take,
  output logic             mode_valid
);

  // ==========================================================================
  // Main control register
  logic [7:0] ctrl_q, ctrl_d;
  logic [1:0] in_fmt, out_fmt, wsel;
  logic       ratio64;
  logic [4:0] wlen;

  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_wr && reg_addr == sapf_pkg::MAIN_CONTROL_ADDR) begin
      ctrl_d = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= sapf_pkg::MAIN_CONTROL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign reg_rdata = (reg_addr == sapf_pkg::MAIN_CONTROL_ADDR) ? ctrl_q : 8'h00;
  assign in_fmt    = ctrl_q[sapf_pkg::IN_FMT_LSB +: 2];
  assign out_fmt   = ctrl_q[sapf_pkg::OUT_FMT_LSB +: 2];
  assign wsel      = ctrl_q[sapf_pkg::WLEN_LSB +: 2];
  assign ratio64   = ctrl_q[sapf_pkg::RATIO_BIT];
  assign wlen      = word_bits(wsel);

  function automatic logic [4:0] word_bits(input logic [1:0] w);
    case (w)
      sapf_pkg::WLEN_16: word_bits = 5'd16;
      sapf_pkg::WLEN_18: word_bits = 5'd18;
      default:           word_bits = 5'd20;
    endcase
  endfunction

  // 32 fs is only legal for 16-bit left-justified on both sides; 11 encodings are invalid
  assign mode_valid = (wsel != 2'h3) && (in_fmt != 2'h3) && (out_fmt != 2'h3) &&
                      (ratio64 || (wsel == sapf_pkg::WLEN_16 && in_fmt == sapf_pkg::FMT_LEFT_JUST &&
                                   out_fmt == sapf_pkg::FMT_LEFT_JUST));

  // ==========================================================================
  // Clock generation from master clock (ref_clk is the master clock)
  logic [2:0] div_q, div_d;
  logic [5:0] bitn_q, bitn_d;
  logic       bclk_q, bclk_d, ws_q, ws_d;
  logic [5:0] bits_per_fs;

  assign bits_per_fs = ratio64 ? 6'(sapf_pkg::BITS_PER_FS_64 - 1) : 6'(sapf_pkg::BITS_PER_FS_32 - 1);

  always_comb begin
    div_d  = div_q + 3'd1;
    bitn_d = bitn_q;
    bclk_d = bclk_q;
    ws_d   = ws_q;
    // A ratio change can reach the fall count with the clock already low; skip it so no edge is lost
    if (div_q == (ratio64 ? sapf_pkg::DIV_64 : sapf_pkg::DIV_32) && bclk_q) begin
      div_d  = 3'd0;
      bclk_d = 1'b0;
      // Word select changes with the falling bit clock so partners see it stable at rise
      bitn_d = (bitn_q >= bits_per_fs) ? 6'd0 : bitn_q + 6'd1;
      ws_d   = (bitn_d > (bits_per_fs >> 1));
    end else if (div_q == ((ratio64 ? sapf_pkg::DIV_64 : sapf_pkg::DIV_32) >> 1)) begin
      bclk_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q  <= 3'd0;
      bitn_q <= 6'd0;
      bclk_q <= 1'b0;
      ws_q   <= 1'b0;
    end else begin
      div_q  <= div_d;
      bitn_q <= bitn_d;
      bclk_q <= bclk_d;
      ws_q   <= ws_d;
    end
  end

  assign word_select_gen = ws_q;
  assign bit_clock_gen   = bclk_q;

  // ==========================================================================
  // Edge detection on the incoming clocks; inputs only, never driven
  logic bclk_in_q, ws_prev_q, ws_at_rise_q;
  logic ws_at_rise_d, ws_prev_d;
  logic bit_rise, bit_fall, ws_edge;

  assign bit_rise = bit_clock & ~bclk_in_q;
  assign bit_fall = ~bit_clock & bclk_in_q;
  assign ws_edge  = bit_rise && (word_select_clock != ws_prev_q);

  always_comb begin
    ws_prev_d    = ws_prev_q;
    ws_at_rise_d = ws_at_rise_q;
    if (bit_rise) begin
      ws_prev_d    = word_select_clock;
      ws_at_rise_d = word_select_clock;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bclk_in_q    <= 1'b0;
      ws_prev_q    <= 1'b0;
      ws_at_rise_q <= 1'b0;
    end else begin
      bclk_in_q    <= bit_clock;
      ws_prev_q    <= ws_prev_d;
      ws_at_rise_q <= ws_at_rise_d;
    end
  end

  // ==========================================================================
  // Receivers for both inputs
  logic stb_a;

  sapf_rx_chan u_rx_a (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .bit_rise    (bit_rise),
    .ws_level    (word_select_clock),
    .ws_edge     (ws_edge),
    .data_in     (serial_in_a),
    .fmt         (in_fmt),
    .wlen        (wlen),
    .left_word   (in_a_left),
    .right_word  (in_a_right),
    .word_strobe (stb_a)
  );

  sapf_rx_chan u_rx_b (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .bit_rise    (bit_rise),
    .ws_level    (word_select_clock),
    .ws_edge     (ws_edge),
    .data_in     (serial_in_b),
    .fmt         (in_fmt),
    .wlen        (wlen),
    .left_word   (in_b_left),
    .right_word  (in_b_right),
    .word_strobe ()
  );

  assign in_valid = stb_a;

  // ==========================================================================
  // Transmitter, timed by the generated clocks
  logic [5:0]  half_len, tx_pos, first_bit;
  logic [19:0] tx_l_q, tx_l_d, tx_r_q, tx_r_d;
  logic        so_q, so_d, take_q, take_d, tx_left;
  logic [19:0] cur_word;
  logic [5:0]  idx;
  logic        gen_fall;

  assign gen_fall = (div_q == (ratio64 ? sapf_pkg::DIV_64 : sapf_pkg::DIV_32)) && bclk_q;
  assign half_len = (bits_per_fs >> 1) + 6'd1;
  // bitn_d is the bit period starting at this falling edge
  assign tx_pos   = (bitn_d > (bits_per_fs >> 1)) ? bitn_d - half_len : bitn_d;
  assign tx_left  = (out_fmt == sapf_pkg::FMT_I2S) ? ~ws_d : ws_d;

  always_comb begin
    case (out_fmt)
      sapf_pkg::FMT_I2S:        first_bit = 6'd1;
      sapf_pkg::FMT_RIGHT_JUST: first_bit = half_len - {1'b0, wlen};
      default:                  first_bit = 6'd0;
    endcase
  end

  always_comb begin
    tx_l_d   = tx_l_q;
    tx_r_d   = tx_r_q;
    so_d     = so_q;
    take_d   = 1'b0;
    cur_word = tx_left ? tx_l_q : tx_r_q;
    idx      = tx_pos - first_bit;
    if (gen_fall) begin
      if (bitn_d == 6'd0) begin
        // Latch a new sample pair at the start of each frame
        tx_l_d   = out_left;
        tx_r_d   = out_right;
        take_d   = 1'b1;
        cur_word = tx_left ? out_left : out_right;
      end
      so_d = 1'b0;
      if (tx_pos >= first_bit && idx < {1'b0, wlen}) begin
        so_d = cur_word[5'(6'd19 - idx)];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_l_q <= 20'h00000;
      tx_r_q <= 20'h00000;
      so_q   <= 1'b0;
      take_q <= 1'b0;
    end else begin
      tx_l_q <= tx_l_d;
      tx_r_q <= tx_r_d;
      so_q   <= so_d;
      take_q <= take_d;
    end
  end

  assign serial_out = so_q;
  assign out_take   = take_q;

endmodule // sapf_port

/* sim/sapf_chk.sv */
`timescale 1ns/10ps
module sapf_chk (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       serial_out,
  input wire logic       word_select_gen,
  input wire logic       bit_clock_gen,
  input wire logic       in_valid,
  input wire logic       out_take,
  input wire logic       mode_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========
  // Shadow control word; age keeps checks off while a new setting settles
  logic [7:0] ctl_q;
  logic [8:0] age_q;
  logic [7:0] wsc_q;
  logic       wsp_q;
  logic       seen_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_q  <= sapf_pkg::MAIN_CONTROL_RESET;
      age_q  <= 9'h000;
      wsc_q  <= 8'h00;
      wsp_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == sapf_pkg::MAIN_CONTROL_ADDR) begin
        ctl_q <= reg_wdata;
        age_q <= 9'h000;
      end else if (age_q != 9'h1ff) begin
        age_q <= age_q + 9'h001;
      end
      wsp_q  <= word_select_gen;
      wsc_q  <= (word_select_gen != wsp_q) ? 8'h00 : wsc_q + 8'h01;
      seen_q <= seen_q | (word_select_gen != wsp_q);
    end
  end
  // ==========
  // Assertions
  chk_phase_len: assert property (
    $changed(word_select_gen) && seen_q && age_q > 9'h12c |-> wsc_q == 8'h7f)
    else $error("generated word select phase length wrong");
  chk_bclk_64: assert property (
    $rose(bit_clock_gen) && ctl_q[6] && age_q > 9'h12c |=> bit_clock_gen ##1 !bit_clock_gen [*2] ##1 bit_clock_gen)
    else $error("bit clock not a quarter of master clock");
  chk_bclk_32: assert property (
    $rose(bit_clock_gen) && ctl_q[6:0] == 7'h00 && age_q > 9'h12c
    |=> bit_clock_gen [*3] ##1 !bit_clock_gen [*4] ##1 bit_clock_gen)
    else $error("bit clock not an eighth of master clock");
  chk_out_fall: assert property ($changed(serial_out) |-> $fell(bit_clock_gen))
    else $error("serial out moved off the falling bit clock");
  chk_ws_fall: assert property ($changed(word_select_gen) |-> $fell(bit_clock_gen))
    else $error("word select moved off the falling bit clock");
  chk_ctl_read: assert property (
    reg_addr == sapf_pkg::MAIN_CONTROL_ADDR |-> reg_rdata == ctl_q)
    else $error("control readback wrong");
  chk_unmapped_zero: assert property (reg_addr != sapf_pkg::MAIN_CONTROL_ADDR |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_flag: assert property (
    age_q > 9'h002 |-> mode_valid == (ctl_q[1:0] != 2'h3 && ctl_q[3:2] != 2'h3 && ctl_q[5:4] != 2'h3 &&
                                      (ctl_q[6] || ctl_q[5:0] == 6'h00)))
    else $error("mode valid flag wrong");
  chk_valid_pulse: assert property (in_valid |=> !in_valid [*8])
    else $error("input valid not a single pulse");
  chk_take_frame: assert property (out_take |-> !word_select_gen && $fell(bit_clock_gen))
    else $error("output take not at frame start");
endmodule  // sapf_chk

bind sapf_port sapf_chk sapf_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .serial_out(serial_out), .word_select_gen(word_select_gen),
  .bit_clock_gen(bit_clock_gen), .in_valid(in_valid), .out_take(out_take), .mode_valid(mode_valid)
);

/* sim/sapf_peer.sv */
`timescale 1ns/10ps
// External clock master and serial source on the inputs, serial sink on the output
module sapf_peer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  fi,
  input  wire logic [1:0]  fo,
  input  wire logic [4:0]  nb,
  input  wire logic [5:0]  sl,
  input  wire logic [19:0] wa_l,
  input  wire logic [19:0] wa_r,
  input  wire logic [19:0] wb_l,
  input  wire logic [19:0] wb_r,
  input  wire logic        sout,
  input  wire logic        bgen,
  input  wire logic        wgen,
  output logic             bclk = 1'b0,
  output logic             ws = 1'b0,
  output logic             sda = 1'b0,
  output logic             sdb = 1'b0,
  output logic             got_l,
  output logic      [19:0] got_w,
  output logic             got_v
);
  int          d, k, j, c;
  logic        wn, lf, bq, wq;
  logic [31:0] sh, x;
  // ==========
  // Source: equal phases of sl slots; spare slots toggle so stale bits never pass
  always @(posedge ref_clk) begin
    d = d + 1;
    if (rst) begin
      d = 0;
      k = 0;
    end else if (d >= 64 / int'(sl)) begin
      d = 0;
      bclk <= !bclk;
      if (bclk) begin
        k = (k + 1) % int'(sl);
        wn = (k == 0) ? !ws : ws;
        j = k - ((fi == sapf_pkg::FMT_I2S) ? 1 : 0)
          - ((fi == sapf_pkg::FMT_RIGHT_JUST) ? int'(sl) - int'(nb) : 0);
        lf = (fi == sapf_pkg::FMT_I2S) ? !wn : wn;
        ws <= wn;
        sda <= (j >= 0 && j < nb) ? (lf ? wa_l[19 - j] : wa_r[19 - j]) : k[0];
        sdb <= (j >= 0 && j < nb) ? (lf ? wb_l[19 - j] : wb_r[19 - j]) : !k[0];
      end
    end
  end
  // ==========
  // Sink: sample on the rising generated clock, cut each phase by format
  always @(posedge ref_clk) begin
    got_v <= !rst && (wgen != wq);
    if (rst) begin
      c = 0;
    end else if (wgen != wq) begin
      x = (fo == sapf_pkg::FMT_RIGHT_JUST) ? sh : sh >> (c - nb - ((fo == sapf_pkg::FMT_I2S) ? 1 : 0));
      got_w <= 20'((x & ((32'h1 << nb) - 32'h1)) << (20 - nb));
      got_l <= (fo == sapf_pkg::FMT_I2S) ? wgen : !wgen;
      c = 0;
    end
    if (bgen && !bq) begin
      sh = {sh[30:0], sout};
      c = c + 1;
    end
    bq = bgen;
    wq = wgen;
  end
endmodule  // sapf_peer

/* sim/tb_serial_audio_port_formats.sv */
`timescale 1ns/10ps
module tb_serial_audio_port_formats;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_addr = sapf_pkg::MAIN_CONTROL_ADDR;
  logic [7:0]  reg_wdata = 8'h00;
  logic [19:0] out_left = 20'h0, out_right = 20'h0;
  logic [19:0] wa_l = 20'h0, wa_r = 20'h0, wb_l = 20'h0, wb_r = 20'h0;
  logic [1:0]  fi = 2'h0, fo = 2'h0;
  logic [4:0]  nb = 5'h10;
  logic [5:0]  sl = 6'h20;
  logic        bclk, ws, sda, sdb, got_l, got_v;
  logic        serial_out, word_select_gen, bit_clock_gen, in_valid, out_take, mode_valid;
  logic [7:0]  reg_rdata;
  logic [19:0] got_w, in_a_left, in_a_right, in_b_left, in_b_right;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h10aa8973;
  logic [79:0] in_q[$];
  logic [20:0] out_q[$];

  always #5 ref_clk = !ref_clk;

  sapf_port sapf_port_inst (
    .ref_clk(ref_clk), .rst(rst), .word_select_clock(ws), .bit_clock(bclk), .serial_in_a(sda),
    .serial_in_b(sdb), .serial_out(serial_out), .word_select_gen(word_select_gen),
    .bit_clock_gen(bit_clock_gen), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .in_a_left(in_a_left), .in_a_right(in_a_right), .in_b_left(in_b_left),
    .in_b_right(in_b_right), .in_valid(in_valid), .out_left(out_left), .out_right(out_right),
    .out_take(out_take), .mode_valid(mode_valid)
  );
  sapf_peer sapf_peer_inst (
    .ref_clk(ref_clk), .rst(rst), .fi(fi), .fo(fo), .nb(nb), .sl(sl), .wa_l(wa_l), .wa_r(wa_r),
    .wb_l(wb_l), .wb_r(wb_r), .sout(serial_out), .bgen(bit_clock_gen), .wgen(word_select_gen),
    .bclk(bclk), .ws(ws), .sda(sda), .sdb(sdb), .got_l(got_l), .got_w(got_w), .got_v(got_v)
  );
  // ==========
  // Helpers
  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [19:0] top(input int n);
    top = ~(20'hfffff >> n);
  endfunction
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= sapf_pkg::MAIN_CONTROL_ADDR;
    @(posedge ref_clk);
  endtask
  // Return two edges after the pulse so a new note never meets the pulse it waited for
  task automatic wait_for(input logic snk);
    int i;
    for (i = 0; i < 600; i++) begin
      @(negedge ref_clk);
      if (snk ? (got_v === 1'b1 && got_l === 1'b0) : (in_valid === 1'b1)) break;
    end
    if (i == 600) mismatches++;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic run_mode(input logic [7:0] cfg);
    int n;
    n = 16 + 2 * cfg[1:0];
    wr(sapf_pkg::MAIN_CONTROL_ADDR, cfg);
    fi <= cfg[3:2];
    fo <= cfg[5:4];
    nb <= 5'(n);
    sl <= cfg[6] ? 6'h20 : 6'h10;
    seed = nx(seed);
    wa_l <= seed[19:0];
    wa_r <= seed[31:12];
    seed = nx(seed);
    wb_l <= seed[19:0];
    wb_r <= seed[31:12];
    seed = nx(seed);
    out_left <= seed[19:0];
    out_right <= seed[31:12];
    wait_for(1'b0);
    wait_for(1'b0);
    in_q.push_back({wa_l & top(n), wa_r & top(n), wb_l & top(n), wb_r & top(n)});
    wait_for(1'b0);
    wait_for(1'b1);
    wait_for(1'b1);
    out_q.push_back({1'b1, out_left & top(n)});
    out_q.push_back({1'b0, out_right & top(n)});
    wait_for(1'b1);
    wait_for(1'b1);
  endtask
  // ==========
  // Watcher: each result takes the oldest note
  always @(posedge ref_clk) begin
    if (in_valid === 1'b1 && in_q.size() > 0)
      chk("in_words", in_q.pop_front(), {in_a_left, in_a_right, in_b_left, in_b_right});
    if (got_v === 1'b1 && out_q.size() > 0)
      chk("out_word", {59'h0, out_q.pop_front()}, {59'h0, got_l, got_w});
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      final_report();
    end
  end
  // ==========
  // Main sequence: register checks, then every table mode, output format differing except in the 32 fs mode
  initial begin
    int wl, f;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("ctl_reset", {72'h0, sapf_pkg::MAIN_CONTROL_RESET}, {72'h0, reg_rdata});
    @(posedge ref_clk);
    wr(8'h02, 8'hff);
    wr(sapf_pkg::MAIN_CONTROL_ADDR, 8'h03);
    @(negedge ref_clk);
    chk("ctl_rw", 80'h03, {72'h0, reg_rdata});
    chk("mode_valid", 80'h0, {79'h0, mode_valid});
    @(posedge ref_clk);
    wr(sapf_pkg::MAIN_CONTROL_ADDR, 8'h01);
    @(negedge ref_clk);
    chk("ratio32_18b", 80'h0, {79'h0, mode_valid});
    @(posedge ref_clk);
    reg_addr <= 8'h02;
    @(negedge ref_clk);
    chk("unmapped", 80'h0, {72'h0, reg_rdata});
    @(posedge ref_clk);
    reg_addr <= sapf_pkg::MAIN_CONTROL_ADDR;
    @(posedge ref_clk);
    for (int m = 0; m < 10; m++) begin
      wl = (m == 0) ? 0 : (m - 1) / 3;
      f = (m == 0) ? 0 : (m - 1) % 3;
      run_mode({1'b0, m != 0, (m == 0) ? 2'h0 : 2'((f + 1) % 3), 2'(f), 2'(wl)});
    end
    if (in_q.size() != 0 || out_q.size() != 0) begin
      mismatches++;
      $display("BAD queues expected 0 seen %0d", in_q.size() + out_q.size());
    end
    final_report();
  end
endmodule  // tb_serial_audio_port_formats
